/* File: pkg/mmd_pkg.sv */
// constants for the program and data memory map decoder
// assumes: an 8-bit core with a 13-bit program counter and four data banks
package mmd_pkg;
    // ==================================================================
    // program memory
    localparam int          PC_WIDTH       = 13;
    localparam int          PROG_PHYS_BITS = 11;            // 2K-word fold window
    localparam logic [12:0] RESET_VECTOR   = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR     = 13'h0004;
    localparam logic [12:0] PROG_TOP_SMALL = 13'h03FF;
    localparam logic [12:0] PROG_TOP_LARGE = 13'h07FF;

    // ==================================================================
    // core register offsets within a bank
    localparam logic [6:0]  OFS_INDIRECT   = 7'h00;
    localparam logic [6:0]  OFS_STATUS     = 7'h03;
    localparam logic [6:0]  OFS_POINTER    = 7'h04;
    localparam logic [6:0]  SFR_TOP        = 7'h1F;         // lowest 32 of banks 0 and 1
    localparam logic [6:0]  ALIAS_SFR_TOP  = 7'h0B;
    localparam logic [6:0]  SHARED_LOW     = 7'h70;

    // ==================================================================
    // status fields and reset values
    localparam int          STAT_PTR_HI_BIT  = 7;           // pointer bank-high bit
    localparam int          STAT_SEL_HI_BIT  = 6;           // bank_sel_high
    localparam int          STAT_SEL_LO_BIT  = 5;           // bank_sel_low
    localparam logic [7:0]  STATUS_RESET     = 8'h18;
    localparam logic [7:0]  POINTER_RESET    = 8'h00;

    // ==================================================================
    // general purpose ram windows
    localparam logic [6:0]  GPR_LO_LARGE   = 7'h20;
    localparam logic [6:0]  GPR_LO_SMALL   = 7'h40;
    localparam logic [6:0]  GPR_HI_B0      = 7'h7F;
    localparam logic [6:0]  GPR_LO_B1      = 7'h20;         // A0h within bank 1
    localparam logic [6:0]  GPR_HI_B1      = 7'h3F;         // BFh within bank 1
    localparam logic [6:0]  GPR_B1_BASE    = 7'h60;         // cell index of A0h
    localparam int          GPR_DEPTH      = 128;

    // ==================================================================
    // decoded target of a data access
    typedef enum logic [2:0] {
        MMD_TGT_NONE, MMD_TGT_STATUS, MMD_TGT_POINTER, MMD_TGT_SFR, MMD_TGT_GPR
    } mmd_target_type;
endpackage

/* File: rtl/mmd_memory_map_decoder.sv */
// program counter and data memory map decoder for the 8-bit core
// assumes: core drives single-cycle read/write strobes on mclk_i; peripherals
// answer their special_function_cell reads combinationally in the same cycle
//
// Operation
// - program counter is thirteen bits, addressing eight thousand fourteen-bit words.
// - 1K words implemented on small variant, 2K words on larger ones.
// - fetches above 2K words fold into the first 2K words; small variant flags 400h-7FFh unimplemented.
// - reset loads address 0000h; a taken interrupt vectors to 0004h.
// - special function cells occupy the lowest 32 addresses of banks 0 and 1; banks 2 and 3 alias only 00h-0Bh.
// - larger variant: 20h-7Fh and A0h-BFh are general RAM.
// - small variant: only 40h-7Fh are general RAM.
// - bank 1 F0h-FFh share storage with bank 0 70h-7Fh.
// - unimplemented locations read zero; writes to them are dropped.
// - bank chosen by bank_sel_high and bank_sel_low: 00,01,10,11 give banks 0-3.
// - general RAM is 64 or 128 bytes, reachable directly or indirectly.
// - address 00h is not a cell; it accesses through the indirect pointer.
`timescale 1ns/1ps
module mmd_memory_map_decoder #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        nrst_i,
    // program counter control from the core
    input  wire logic        pc_inc_i,
    input  wire logic        pc_load_i,
    input  wire logic [12:0] pc_load_val_i,
    input  wire logic        irq_take_i,
    // program memory side
    output logic      [12:0] pc_o,
    output logic      [10:0] prog_addr_o,
    output logic             prog_impl_o,
    // data access from the core
    input  wire logic [6:0]  dm_addr_i,
    input  wire logic        dm_rd_i,
    input  wire logic        dm_wr_i,
    input  wire logic [7:0]  dm_wdata_i,
    output logic      [7:0]  dm_rdata_o,
    output logic             dm_rvalid_o,
    // core register view
    output logic      [7:0]  status_o,
    output logic      [7:0]  pointer_o,
    // peripheral special function cells
    output logic             sfr_rd_o,
    output logic             sfr_wr_o,
    output logic      [7:0]  sfr_addr_o,
    output logic      [7:0]  sfr_wdata_o,
    input  wire logic [7:0]  sfr_rdata_i
);
    // ==================================================================
    // program counter
    logic [12:0] pc_reg;
    logic [12:0] pc_next;

    // next program address: interrupt beats load beats increment
    always_comb begin
        pc_next = pc_reg;
        if (irq_take_i) begin
            pc_next = mmd_pkg::IRQ_VECTOR;
        end else if (pc_load_i) begin
            pc_next = pc_load_val_i;
        end else if (pc_inc_i) begin
            pc_next = pc_reg + 13'h0001;
        end
    end

    // register the counter
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            pc_reg <= mmd_pkg::RESET_VECTOR;
        end else begin
            pc_reg <= pc_next;
        end
    end

    // fetch address folds into the 2K window, upper bits ignored
    assign pc_o        = pc_reg;
    assign prog_addr_o = pc_reg[mmd_pkg::PROG_PHYS_BITS-1:0];
    assign prog_impl_o = SMALL_VARIANT
                       ? ({2'b00, prog_addr_o} <= mmd_pkg::PROG_TOP_SMALL)
                       : ({2'b00, prog_addr_o} <= mmd_pkg::PROG_TOP_LARGE);

    // ==================================================================
    // core registers and ram storage
    logic [7:0]  status_reg;
    logic [7:0]  status_next;
    logic [7:0]  pointer_reg;
    logic [7:0]  pointer_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [7:0]  gpr_mem [mmd_pkg::GPR_DEPTH];

    // ==================================================================
    // address formation and decode
    logic [8:0]  full_addr;
    logic [1:0]  bank;
    logic [6:0]  ofs;
    logic        canon_ok;
    logic [7:0]  canon;
    logic [6:0]  gpr_idx;
    mmd_pkg::mmd_target_type tgt;

    // direct uses bank select bits, indirect uses the pointer
    always_comb begin
        if (dm_addr_i == mmd_pkg::OFS_INDIRECT) begin
            full_addr = {status_reg[mmd_pkg::STAT_PTR_HI_BIT], pointer_reg};
        end else begin
            full_addr = {status_reg[mmd_pkg::STAT_SEL_HI_BIT],
                         status_reg[mmd_pkg::STAT_SEL_LO_BIT], dm_addr_i};
        end
    end

    assign bank = full_addr[8:7];
    assign ofs  = full_addr[6:0];

    // fold every bank onto a canonical bank 0 / bank 1 address
    always_comb begin
        canon_ok = 1'b1;
        canon    = {1'b0, ofs};
        case (bank)
            2'd0: begin
                canon = {1'b0, ofs};
            end
            2'd1: begin
                canon = (ofs >= mmd_pkg::SHARED_LOW) ? {1'b0, ofs}
                                                     : {1'b1, ofs};
            end
            2'd2: begin
                canon_ok = (ofs <= mmd_pkg::ALIAS_SFR_TOP)
                         || (ofs >= mmd_pkg::SHARED_LOW);
                canon    = {1'b0, ofs};
            end
            2'd3: begin
                canon_ok = (ofs <= mmd_pkg::ALIAS_SFR_TOP)
                         || (ofs >= mmd_pkg::SHARED_LOW);
                canon    = (ofs >= mmd_pkg::SHARED_LOW) ? {1'b0, ofs} : {1'b1, ofs};
            end
            default: begin
                canon_ok = 1'b0;
            end
        endcase
    end

    // classify the canonical address
    always_comb begin
        tgt     = mmd_pkg::MMD_TGT_NONE;
        gpr_idx = 7'h00;
        if (!canon_ok) begin
            tgt = mmd_pkg::MMD_TGT_NONE;
        end else if (canon[6:0] <= mmd_pkg::SFR_TOP) begin
            case (canon[6:0])
                mmd_pkg::OFS_INDIRECT: tgt = mmd_pkg::MMD_TGT_NONE;
                mmd_pkg::OFS_STATUS:   tgt = mmd_pkg::MMD_TGT_STATUS;
                mmd_pkg::OFS_POINTER:  tgt = mmd_pkg::MMD_TGT_POINTER;
                default:               tgt = mmd_pkg::MMD_TGT_SFR;
            endcase
        end else if (!canon[7]) begin
            if (SMALL_VARIANT) begin
                if (canon[6:0] >= mmd_pkg::GPR_LO_SMALL) begin
                    tgt     = mmd_pkg::MMD_TGT_GPR;
                    gpr_idx = canon[6:0] - mmd_pkg::GPR_LO_SMALL;
                end
            end else if (canon[6:0] >= mmd_pkg::GPR_LO_LARGE) begin
                tgt     = mmd_pkg::MMD_TGT_GPR;
                gpr_idx = canon[6:0] - mmd_pkg::GPR_LO_LARGE;
            end
        end else if (!SMALL_VARIANT && canon[6:0] >= mmd_pkg::GPR_LO_B1
                     && canon[6:0] <= mmd_pkg::GPR_HI_B1) begin
            tgt     = mmd_pkg::MMD_TGT_GPR;
            gpr_idx = canon[6:0] - mmd_pkg::GPR_LO_B1 + mmd_pkg::GPR_B1_BASE;
        end
    end

    // peripheral cell strobes, decoded in the request cycle
    assign sfr_rd_o    = dm_rd_i && (tgt == mmd_pkg::MMD_TGT_SFR);
    assign sfr_wr_o    = dm_wr_i && (tgt == mmd_pkg::MMD_TGT_SFR);
    assign sfr_addr_o  = canon;
    assign sfr_wdata_o = dm_wdata_i;

    // ==================================================================
    // next values of core registers and read data
    always_comb begin
        status_next  = status_reg;
        pointer_next = pointer_reg;
        rdata_next   = rdata_reg;
        rvalid_next  = dm_rd_i;
        if (dm_wr_i) begin
            case (tgt)
                mmd_pkg::MMD_TGT_STATUS:  status_next  = dm_wdata_i;
                mmd_pkg::MMD_TGT_POINTER: pointer_next = dm_wdata_i;
                default:                  status_next  = status_reg;
            endcase
        end
        if (dm_rd_i) begin
            case (tgt)
                mmd_pkg::MMD_TGT_STATUS:  rdata_next = status_reg;
                mmd_pkg::MMD_TGT_POINTER: rdata_next = pointer_reg;
                mmd_pkg::MMD_TGT_SFR:     rdata_next = sfr_rdata_i;
                mmd_pkg::MMD_TGT_GPR:     rdata_next = gpr_mem[gpr_idx];
                default:                  rdata_next = 8'h00;
            endcase
        end
    end

    // register core state and read data
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            status_reg  <= mmd_pkg::STATUS_RESET;
            pointer_reg <= mmd_pkg::POINTER_RESET;
            rdata_reg   <= 8'h00;
            rvalid_reg  <= 1'b0;
        end else begin
            status_reg  <= status_next;
            pointer_reg <= pointer_next;
            rdata_reg   <= rdata_next;
            rvalid_reg  <= rvalid_next;
        end
    end

    // ram cells keep no reset; only decoded ram writes land
    always_ff @(posedge mclk_i) begin
        if (dm_wr_i && tgt == mmd_pkg::MMD_TGT_GPR) begin
            gpr_mem[gpr_idx] <= dm_wdata_i;
        end
    end

    assign dm_rdata_o  = rdata_reg;
    assign dm_rvalid_o = rvalid_reg;
    assign status_o    = status_reg;
    assign pointer_o   = pointer_reg;
endmodule

/* File: tb/mmd_periph_model.sv */
// peripheral cell responder for the special function port
// assumes: answers in the same cycle as sfr_rd_o, as the decoder expects
`timescale 1ns/1ps
module mmd_periph_model (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    // strobes from the decoder
    input  wire logic       sfr_rd_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic [7:0] sfr_wdata_i,
    // read data back to the decoder
    output logic      [7:0] sfr_rdata_o,
    // last cell write seen, for the bench
    output logic      [7:0] wr_addr_o,
    output logic      [7:0] wr_data_o
);
    logic [7:0] junk_reg;
    // ==========================================
    // junk pattern moves every cycle; cell writes are recorded
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            junk_reg  <= 8'hC3;
            wr_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
        end else begin
            junk_reg <= junk_reg + 8'h3B;
            if (sfr_wr_i) begin
                wr_addr_o <= sfr_addr_i;
                wr_data_o <= sfr_wdata_i;
            end
        end
    end
    // selected cell answers with an address-keyed value
    assign sfr_rdata_o = sfr_rd_i ? (sfr_addr_i ^ 8'h5A) : junk_reg;
endmodule

/* File: tb/mmd_assertions.sv */
// port checker for the memory map decoder
// assumes: bound onto every decoder instance
`timescale 1ns/1ps
module mmd_assertions #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input logic        mclk_i,
    input logic        nrst_i,
    input logic        pc_inc_i,
    input logic        pc_load_i,
    input logic [12:0] pc_load_val_i,
    input logic        irq_take_i,
    input logic [12:0] pc_o,
    input logic [10:0] prog_addr_o,
    input logic        prog_impl_o,
    input logic [6:0]  dm_addr_i,
    input logic        dm_rd_i,
    input logic        dm_wr_i,
    input logic [7:0]  dm_wdata_i,
    input logic        dm_rvalid_o,
    input logic [7:0]  dm_rdata_o,
    input logic [7:0]  status_o,
    input logic [7:0]  pointer_o,
    input logic        sfr_rd_o,
    input logic [7:0]  sfr_addr_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ==========================================
    // step sequences
    sequence s_rd;     dm_rd_i; endsequence
    sequence s_wr_ptr; dm_wr_i && dm_addr_i == 7'h04; endsequence
    a_reset_vals: assert property ($rose(nrst_i)
        |-> pc_o == 13'h0000 && status_o == 8'h18)
        else $error("reset values wrong");
    a_irq_vector: assert property (irq_take_i |=> pc_o == 13'h0004)
        else $error("interrupt vector wrong");
    a_pc_incr: assert property (pc_inc_i && !pc_load_i && !irq_take_i
        |=> pc_o == $past(pc_o) + 13'h0001)
        else $error("pc increment wrong");
    a_pc_load: assert property (pc_load_i && !irq_take_i
        |=> pc_o == $past(pc_load_val_i))
        else $error("pc load wrong");
    a_fetch_fold: assert property (prog_addr_o == pc_o[10:0])
        else $error("fetch fold wrong");
    a_impl_range: assert property (prog_impl_o == (!SMALL_VARIANT || !pc_o[10]))
        else $error("implemented flag wrong");
    a_read_answer: assert property (s_rd |=> dm_rvalid_o)
        else $error("read not answered");
    a_ptr_write: assert property (s_wr_ptr |=> pointer_o == $past(dm_wdata_i))
        else $error("pointer write lost");
    a_sfr_bank: assert property (dm_rd_i && dm_addr_i == 7'h01
        |-> sfr_rd_o && sfr_addr_o == {status_o[5], 7'h01})
        else $error("cell address wrong");
    a_hole_zero: assert property (dm_rd_i && status_o[6:5] == 2'b10
        && dm_addr_i >= 7'h20 && dm_addr_i <= 7'h6F |=> dm_rdata_o == 8'h00)
        else $error("unimplemented read not zero");
endmodule
bind mmd_memory_map_decoder mmd_assertions #(.SMALL_VARIANT(SMALL_VARIANT)) i_chk (.*);

/* File: tb/memory_map_decoder_tb.sv */
// self-checking bench for the memory map decoder, large and small variants
// assumes: peripheral model on the cell port, checker bound in
`timescale 1ns/1ps
module memory_map_decoder_tb;
    logic mclk_i, nrst_i, pc_inc_i, pc_load_i, irq_take_i, dm_rd_i, dm_wr_i, sfr_rd_o, dm_rvalid_o;
    logic [12:0] pc_load_val_i, pc_o;
    logic [10:0] prog_addr_o;
    logic        prog_impl_o;
    logic [6:0]  dm_addr_i;
    logic [7:0]  dm_wdata_i, dm_rdata_o, status_o, pointer_o, sfr_addr_o, sfr_wdata_o, sfr_rdata_i;
    logic        sfr_wr_o;
    logic        impl_s, rvalid_s, sfr_rd_s, sfr_wr_s;
    logic [7:0]  rdata_s, sfr_addr_s, sfr_wdata_s, sfr_rdata_s, per_wr_addr, per_wr_data;
    int n_fail, n_tests, cyc;
    mmd_memory_map_decoder #(.SMALL_VARIANT(1'b0)) i_dut (.*);
    mmd_periph_model i_per (.mclk_i, .nrst_i, .sfr_rd_i(sfr_rd_o), .sfr_wr_i(sfr_wr_o),
        .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i),
        .wr_addr_o(per_wr_addr), .wr_data_o(per_wr_data));
    // small variant beside the large one, same core inputs
    mmd_memory_map_decoder #(.SMALL_VARIANT(1'b1)) i_dut_small (.mclk_i, .nrst_i,
        .pc_inc_i, .pc_load_i, .pc_load_val_i, .irq_take_i, .pc_o(), .prog_addr_o(),
        .prog_impl_o(impl_s), .dm_addr_i, .dm_rd_i, .dm_wr_i, .dm_wdata_i,
        .dm_rdata_o(rdata_s), .dm_rvalid_o(rvalid_s), .status_o(), .pointer_o(),
        .sfr_rd_o(sfr_rd_s), .sfr_wr_o(sfr_wr_s), .sfr_addr_o(sfr_addr_s),
        .sfr_wdata_o(sfr_wdata_s), .sfr_rdata_i(sfr_rdata_s));
    mmd_periph_model i_per_s (.mclk_i, .nrst_i, .sfr_rd_i(sfr_rd_s), .sfr_wr_i(sfr_wr_s),
        .sfr_addr_i(sfr_addr_s), .sfr_wdata_i(sfr_wdata_s), .sfr_rdata_o(sfr_rdata_s),
        .wr_addr_o(), .wr_data_o());
    // ==========================================
    // clock and cycle ceiling
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ==========================================
    // bus cycles
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        {dm_wr_i, dm_addr_i, dm_wdata_i} = {1'b1, a, d};
        @(negedge mclk_i);
        dm_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        {dm_rd_i, dm_addr_i} = {1'b1, a};
        @(negedge mclk_i);
        dm_rd_i = 1'b0;
        chk({12'h000, dm_rvalid_o}, 13'h0001);
        chk({5'h00, dm_rdata_o}, {5'h00, exp});
    endtask
    task automatic bank(input logic [1:0] b);
        wr(7'h03, {1'b0, b, 5'h18});
    endtask
    task automatic pc_op(input logic i, input logic l, input logic [12:0] v, input logic q);
        @(negedge mclk_i);
        {pc_inc_i, pc_load_i, pc_load_val_i, irq_take_i} = {i, l, v, q};
        @(negedge mclk_i);
        {pc_inc_i, pc_load_i, irq_take_i} = 3'b000;
    endtask
    // ==========================================
    // scenarios
    task automatic t_pc();
        chk(pc_o, 13'h0000);
        pc_op(1'b0, 1'b1, 13'h1FFF, 1'b0);
        pc_op(1'b1, 1'b0, 13'h0000, 1'b0);
        chk(pc_o, 13'h0000);
        pc_op(1'b0, 1'b1, 13'h0C05, 1'b0);
        chk({2'b00, prog_addr_o}, 13'h0405);
        chk({12'h000, prog_impl_o}, 13'h0001);
        chk({12'h000, impl_s}, 13'h0000);
        pc_op(1'b1, 1'b1, 13'h0123, 1'b1);
        chk(pc_o, 13'h0004);
    endtask
    task automatic t_ram();
        bank(2'b00);
        wr(7'h20, 8'h11);
        wr(7'h7F, 8'h7E);
        bank(2'b01);
        wr(7'h20, 8'hA0);
        rd(7'h7F, 8'h7E);
        wr(7'h40, 8'hEE);
        rd(7'h40, 8'h00);
        rd(7'h20, 8'hA0);
        bank(2'b10);
        rd(7'h7F, 8'h7E);
        rd(7'h20, 8'h00);
        bank(2'b11);
        rd(7'h7F, 8'h7E);
        bank(2'b00);
        rd(7'h20, 8'h11);
    endtask
    task automatic t_ind();
        wr(7'h04, 8'hA0);
        chk({5'h00, pointer_o}, 13'h00A0);
        rd(7'h00, 8'hA0);
        wr(7'h04, 8'h00);
        rd(7'h00, 8'h00);
    endtask
    task automatic t_sfr();
        for (int b = 0; b < 4; b++) begin
            bank(b[1:0]);
            chk({5'h00, status_o}, {5'h00, 1'b0, b[1:0], 5'h18});
            rd(7'h01, {b[0], 7'h01} ^ 8'h5A);
        end
    endtask
    // read on the small variant instance
    task automatic rs(input logic [6:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        {dm_rd_i, dm_addr_i} = {1'b1, a};
        @(negedge mclk_i);
        dm_rd_i = 1'b0;
        chk({12'h000, rvalid_s}, 13'h0001);
        chk({5'h00, rdata_s}, {5'h00, exp});
    endtask
    task automatic t_rst();
        pc_op(1'b0, 1'b1, 13'h0ABC, 1'b0);
        wr(7'h04, 8'h5A);
        @(negedge mclk_i);
        nrst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        nrst_i = 1'b1;
        chk(pc_o, 13'h0000);
        chk({5'h00, pointer_o}, 13'h0000);
        chk({5'h00, status_o}, 13'h0018);
    endtask
    task automatic t_sfr_wr();
        bank(2'b11);
        wr(7'h05, 8'hC7);
        chk({5'h00, per_wr_addr}, 13'h0085);
        chk({5'h00, per_wr_data}, 13'h00C7);
        bank(2'b00);
        chk({5'h00, per_wr_addr}, 13'h0085);
        wr(7'h1F, 8'h3C);
        chk({5'h00, per_wr_addr}, 13'h001F);
        chk({5'h00, per_wr_data}, 13'h003C);
    endtask
    task automatic t_small();
        bank(2'b00);
        wr(7'h20, 8'h55);
        wr(7'h40, 8'h66);
        wr(7'h7F, 8'h77);
        rs(7'h20, 8'h00);
        rs(7'h40, 8'h66);
        bank(2'b01);
        wr(7'h20, 8'h88);
        rs(7'h20, 8'h00);
        rs(7'h7F, 8'h77);
    endtask
    initial begin
        {n_fail, n_tests, cyc} = '0;
        {nrst_i, pc_inc_i, pc_load_i, irq_take_i, dm_rd_i, dm_wr_i} = '0;
        {pc_load_val_i, dm_addr_i, dm_wdata_i} = '0;
        repeat (20) @(negedge mclk_i);
        nrst_i = 1'b1;
        chk({5'h00, status_o}, 13'h0018);
        t_pc();
        t_rst();
        t_ram();
        t_ind();
        t_sfr();
        t_sfr_wr();
        t_small();
        end_sim();
    end
endmodule
